// File: rtl/etbts_map.vh
`ifndef ETBTS_MAP_VH
`define ETBTS_MAP_VH
// Register byte addresses
`define ETBTS_CLOCK_SELECTION_ADDR 12'h000
`define ETBTS_TX_INTERFACE_CONTROL_ADDR 12'h020
`define ETBTS_STATUS_ADDR 12'h040
// Clock selection fields
`define ETBTS_CS_LOSS_EN_BIT 4
`define ETBTS_CS_SRC_LO 0
`define ETBTS_CS_SRC_HI 1
`define ETBTS_CS_RESET 8'h00
// Timing source codes
`define ETBTS_SRC_LOOP0 2'h0
`define ETBTS_SRC_SERCLK 2'h1
`define ETBTS_SRC_OSC 2'h2
`define ETBTS_SRC_LOOP3 2'h3
// Transmit interface control fields
`define ETBTS_TIC_MUX_BIT 2
`define ETBTS_TIC_MODE_LO 0
`define ETBTS_TIC_MODE_HI 1
`define ETBTS_TIC_RESET 8'h00
// Back-plane rate codes
`define ETBTS_RATE_LEGACY 3'h0
`define ETBTS_RATE_MVIP 3'h1
`define ETBTS_RATE_4M 3'h2
`define ETBTS_RATE_8M 3'h3
`define ETBTS_RATE_NONE 3'h4
`define ETBTS_RATE_BITMUX 3'h5
`define ETBTS_RATE_HMVIP 3'h6
`define ETBTS_RATE_H100 3'h7
// E1 framing
`define ETBTS_FRAME_BITS 256
`define ETBTS_MF_FRAMES 16
// Loss detector: clock missing for this many pclk cycles
`define ETBTS_BIT_PERIOD_NS 488
`define ETBTS_CLK_PERIOD_NS 40
`define ETBTS_LOSS_BITS 4
`define ETBTS_LOSS_CYCLES ((`ETBTS_LOSS_BITS * `ETBTS_BIT_PERIOD_NS) / `ETBTS_CLK_PERIOD_NS)
`endif

// File: rtl/etbts_frame_counter.v
`include "etbts_map.vh"
// Frame and multiframe bit counter stepped on each transmit bit tick
module etbts_frame_counter
(
  input wire pclk,
  input wire presetn,
  input wire bit_tick,
  output reg frame_last_r,
  output reg mf_last_r
);
  reg [7:0] bit_cnt_r;
  reg [3:0] frm_cnt_r;
  wire bit_end;
  wire frm_end;

  assign bit_end = (bit_cnt_r == 8'hFF);
  assign frm_end = (frm_cnt_r == 4'hF);

  // Bit counter advances once per bit, frame counter once per frame; flags mark the final bit position
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_cnt_r <= 8'h00;
      frm_cnt_r <= 4'h0;
      frame_last_r <= 1'b0;
      mf_last_r <= 1'b0;
    end
    else if (bit_tick)
    begin
      bit_cnt_r <= bit_cnt_r + 8'h01;
      if (bit_end)
        frm_cnt_r <= frm_cnt_r + 4'h1;
      frame_last_r <= (bit_cnt_r == 8'hFE);
      mf_last_r <= (bit_cnt_r == 8'hFE) && frm_end;
    end
  end
endmodule

// File: rtl/etbts_top.v
// Function
// R1 - Clock selection bit 4 enables the clock-loss detector, read/write.
// R2 - Enabled loop timing with lost recovered clock falls back to oscillator clock.
// R3 - Loss enable ignored when serial clock or oscillator clock is source.
// R4 - Loop timing drives recovered clock out; sync pins become outputs.
// R5 - Loop timing: frame sync high one bit at last frame bit.
// R6 - Loop timing: multiframe sync high one bit at multiframe's last bit.
// R7 - Terminal equipment starts next frame or multiframe after the pulses.
// R8 - Interface control bit 2 selects multiplexed back-plane, read/write.
// R9 - Non-multiplexed mode select picks legacy, MVIP, 4.096 or 8.192 rate.
// R10 - Multiplexed mode select picks bit-mux, HMVIP or H.100; 00 undefined.
// R11 - Non-multiplexed channels use their own clock, data and sync pins.
// R12 - MVIP, 4.096 and 8.192 rates make all four pins inputs.
// R13 - Terminal equipment drives serial clock at 2.048 MHz at these rates.
// R14 - Multiframe sync pin becomes back-plane input clock at these rates.
// R15 - Sync pulses come from bit counters clocked by the driven-out clock; in fallback they count the oscillator clock instead.
`include "etbts_map.vh"
module etbts_top
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire recovered_clock,
  input wire oscillator_clock,
  input wire tx_serial_clock_in,
  output reg tx_serial_clock_out,
  output reg tx_serial_clock_oen_n,
  input wire tx_serial_data,
  output reg tx_serial_data_oen_n,
  input wire tx_frame_sync_in,
  output reg tx_frame_sync_out,
  output reg tx_frame_sync_oen_n,
  input wire tx_multiframe_sync_in,
  output reg tx_multiframe_sync_out,
  output reg tx_multiframe_sync_oen_n,
  output reg tx_timing_clock,
  output reg fallback_active,
  output reg tx_backplane_input_clock,
  output reg [2:0] backplane_rate,
  output reg channel_muxed
);
  localparam ST_LOOP = 3'b001;
  localparam ST_FALLBACK = 3'b010;
  localparam ST_OTHER = 3'b100;

  reg [7:0] clock_selection_r;
  reg [7:0] tx_interface_control_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg rec_d_r;
  reg osc_d_r;
  reg [11:0] loss_cnt_r;
  reg clk_lost_r;
  reg [2:0] rate_nxt;
  reg [31:0] rd_nxt;
  wire [1:0] src;
  wire loop_src;
  wire loss_en;
  wire rec_edge;
  wire osc_edge;
  wire bit_tick;
  wire frame_last;
  wire mf_last;
  wire wr_en;
  wire rd_en;
  wire addr_ok;
  wire four_in;

  assign src = clock_selection_r[`ETBTS_CS_SRC_HI:`ETBTS_CS_SRC_LO];
  assign loop_src = (src == `ETBTS_SRC_LOOP0) || (src == `ETBTS_SRC_LOOP3);
  // Enable only counts in loop timing
  assign loss_en = clock_selection_r[`ETBTS_CS_LOSS_EN_BIT] && loop_src; // R1 R3
  assign rec_edge = recovered_clock && !rec_d_r;
  assign osc_edge = oscillator_clock && !osc_d_r;

  // APB decode: one wait state, error on unmapped address
  assign addr_ok = (paddr == `ETBTS_CLOCK_SELECTION_ADDR) ||
    (paddr == `ETBTS_TX_INTERFACE_CONTROL_ADDR) || (paddr == `ETBTS_STATUS_ADDR);
  // Write lands on the edge that ends the access, with pready high
  assign wr_en = psel && penable && pwrite && pready && addr_ok;
  assign rd_en = psel && penable && !pwrite && !pready;

  // Edge history of the timing clocks, inputs taken as synchronous
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rec_d_r <= 1'b0;
      osc_d_r <= 1'b0;
    end
    else
    begin
      rec_d_r <= recovered_clock;
      osc_d_r <= oscillator_clock;
    end
  end

  // Loss detector: no recovered edge for several bit periods means lost
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loss_cnt_r <= 12'h000;
      clk_lost_r <= 1'b0;
    end
    else if (!loss_en || rec_edge)
    begin
      loss_cnt_r <= 12'h000;
      clk_lost_r <= 1'b0; // R2
    end
    else if ({20'h00000, loss_cnt_r} == `ETBTS_LOSS_CYCLES - 1)
      clk_lost_r <= 1'b1; // R2
    else
      loss_cnt_r <= loss_cnt_r + 12'h001;
  end

  // Timing source state
  always @*
  begin
    case (state_r)
      ST_LOOP:
        state_nxt = !loop_src ? ST_OTHER : (clk_lost_r ? ST_FALLBACK : ST_LOOP); // R2
      ST_FALLBACK:
        state_nxt = !loop_src ? ST_OTHER : (clk_lost_r ? ST_FALLBACK : ST_LOOP); // R2
      ST_OTHER:
        state_nxt = loop_src ? ST_LOOP : ST_OTHER; // R3
      default:
        state_nxt = ST_OTHER;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= ST_OTHER;
    else
      state_r <= state_nxt;
  end

  // Bit tick from the recovered clock in loop timing, the oscillator clock in fallback, none otherwise
  assign bit_tick = (state_r == ST_LOOP) ? rec_edge :
    (state_r == ST_FALLBACK) ? osc_edge : 1'b0; // R15

  etbts_frame_counter u_cnt
  (
    .pclk(pclk),
    .presetn(presetn),
    .bit_tick(bit_tick),
    .frame_last_r(frame_last),
    .mf_last_r(mf_last)
  );

  // Rate decode from multiplex enable and mode select
  always @*
  begin
    rate_nxt = {tx_interface_control_r[`ETBTS_TIC_MUX_BIT],
      tx_interface_control_r[`ETBTS_TIC_MODE_HI:`ETBTS_TIC_MODE_LO]}; // R8 R9 R10
  end

  // High-speed non-muxed rates turn every pin into an input
  assign four_in = !tx_interface_control_r[`ETBTS_TIC_MUX_BIT] &&
    (tx_interface_control_r[`ETBTS_TIC_MODE_HI:`ETBTS_TIC_MODE_LO] != 2'h0); // R12

  // Pin drive, all outputs registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_serial_clock_out <= 1'b0;
      tx_serial_clock_oen_n <= 1'b1;
      tx_serial_data_oen_n <= 1'b1;
      tx_frame_sync_out <= 1'b0;
      tx_frame_sync_oen_n <= 1'b1;
      tx_multiframe_sync_out <= 1'b0;
      tx_multiframe_sync_oen_n <= 1'b1;
      tx_timing_clock <= 1'b0;
      fallback_active <= 1'b0;
      tx_backplane_input_clock <= 1'b0;
      backplane_rate <= `ETBTS_RATE_LEGACY;
      channel_muxed <= 1'b0;
    end
    else
    begin
      // Loop timing drives clock and syncs out unless pins forced in
      tx_serial_clock_out <= recovered_clock; // R4
      tx_serial_clock_oen_n <= !(loop_src && !four_in); // R4 R12
      tx_serial_data_oen_n <= 1'b1; // R11
      tx_frame_sync_oen_n <= !(loop_src && !four_in); // R4 R12
      tx_multiframe_sync_oen_n <= !(loop_src && !four_in); // R4 R12
      // Pulse lasts exactly one bit: held between bit ticks
      tx_frame_sync_out <= loop_src && frame_last; // R5
      tx_multiframe_sync_out <= loop_src && mf_last; // R6
      tx_timing_clock <= (state_r == ST_LOOP) ? recovered_clock :
        ((state_r == ST_FALLBACK) || (src == `ETBTS_SRC_OSC)) ? oscillator_clock : tx_serial_clock_in; // R2 R3
      fallback_active <= (state_r == ST_FALLBACK);
      // Multiframe pin doubles as back-plane clock input at high rates
      tx_backplane_input_clock <= four_in && tx_multiframe_sync_in; // R14
      backplane_rate <= rate_nxt; // R9 R10
      channel_muxed <= tx_interface_control_r[`ETBTS_TIC_MUX_BIT]; // R8
    end
  end

  // Register writes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_selection_r <= `ETBTS_CS_RESET;
      tx_interface_control_r <= `ETBTS_TIC_RESET;
    end
    else if (wr_en)
    begin
      if (paddr == `ETBTS_CLOCK_SELECTION_ADDR)
        clock_selection_r <= pwdata[7:0]; // R1
      if (paddr == `ETBTS_TX_INTERFACE_CONTROL_ADDR)
        tx_interface_control_r <= pwdata[7:0]; // R8
    end
  end

  // Read mux
  always @*
  begin
    rd_nxt = 32'h00000000;
    case (paddr)
      `ETBTS_CLOCK_SELECTION_ADDR:
        rd_nxt = {24'h000000, clock_selection_r};
      `ETBTS_TX_INTERFACE_CONTROL_ADDR:
        rd_nxt = {24'h000000, tx_interface_control_r};
      `ETBTS_STATUS_ADDR:
        rd_nxt = {26'h0000000, four_in, rate_nxt, clk_lost_r, state_r == ST_FALLBACK};
      default:
        rd_nxt = 32'h00000000;
    endcase
  end

  // One wait state: pready rises the cycle after penable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (rd_en)
        prdata <= rd_nxt;
    end
  end
endmodule

// File: test/etbts_top_assertions.sv
module etbts_checker
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire recovered_clock,
  input wire tx_serial_clock_out,
  input wire tx_serial_clock_oen_n,
  input wire tx_serial_data_oen_n,
  input wire tx_frame_sync_out,
  input wire tx_frame_sync_oen_n,
  input wire tx_multiframe_sync_out,
  input wire tx_multiframe_sync_oen_n,
  input wire fallback_active,
  input wire [2:0] backplane_rate,
  input wire channel_muxed
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_apb_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_mux_flag: assert property (channel_muxed == backplane_rate[2])
    else $error("mux flag off");
  chk_pins_in: assert property ($stable(backplane_rate) && backplane_rate inside {3'h1, 3'h2, 3'h3}
    |-> tx_serial_clock_oen_n && tx_frame_sync_oen_n && tx_multiframe_sync_oen_n)
    else $error("pins not inputs");
  chk_data_in: assert property (tx_serial_data_oen_n)
    else $error("data pin driven");
  chk_clk_copy: assert property (!tx_serial_clock_oen_n && !fallback_active && !$past(fallback_active)
    |-> tx_serial_clock_out == $past(recovered_clock))
    else $error("serial clock not recovered");
  chk_mf_in_f: assert property (tx_multiframe_sync_out |-> tx_frame_sync_out)
    else $error("multiframe pulse off frame end");
  chk_fb_clear: assert property ($rose(recovered_clock) |-> ##[1:3] !fallback_active)
    else $error("fallback kept with clock back");
  cover property ($rose(fallback_active));
  cover property ($rose(tx_multiframe_sync_out));
  cover property (pslverr);
endmodule

// File: test/etbts_te_model.sv
module etbts_te_model
(
  input wire pclk,
  input wire [2:0] rate,
  input wire fsync_wire,
  output logic ser_clk = 1'h0,
  output logic in_clk = 1'h0,
  output logic dat = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cs = 4'h0;
  logic [3:0] ci = 4'h0;
  int frames_seen = 0;
  wire [3:0] half = (rate == 3'h1) ? 4'h5 : (rate == 3'h2) ? 4'h2 : 4'h1;
  // Serial clock fixed, input clock scaled to rate
  always @(posedge pclk)
  begin
    cs <= (cs == 4'h5) ? 4'h0 : cs + 4'h1;
    ser_clk <= (cs == 4'h5) ? ~ser_clk : ser_clk;
    ci <= (ci >= half) ? 4'h0 : ci + 4'h1;
    in_clk <= (ci >= half) ? ~in_clk : in_clk;
    dat <= ~dat; // Never a stale level
  end
  // One frame counted on each pulse
  always @(posedge fsync_wire) frames_seen++;
endmodule

// File: test/etbts_top_tb.sv
module etbts_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic recovered_clock = 1'h0, oscillator_clock = 1'h0, run = 1'h1, ph = 1'h0, err;
  wire [31:0] prdata;
  wire pready, pslverr, tx_serial_clock_out, tx_serial_clock_oen_n, tx_serial_data_oen_n, tx_frame_sync_out;
  wire tx_frame_sync_oen_n, tx_multiframe_sync_out, tx_multiframe_sync_oen_n, tx_timing_clock, fallback_active;
  wire tx_backplane_input_clock, channel_muxed, ser_clk, in_clk, tx_serial_data;
  wire [2:0] backplane_rate;
  int num_errors = 0, tests_run = 0, f = 0, hi = 0, mh = 0, n = 0, m = 0, a, b, c, d;
  time t;
  // Pin level from whichever side drives
  wire tx_serial_clock_in = tx_serial_clock_oen_n ? ser_clk : tx_serial_clock_out;
  wire tx_frame_sync_in = tx_frame_sync_oen_n ? 1'h0 : tx_frame_sync_out;
  wire tx_multiframe_sync_in = tx_multiframe_sync_oen_n ? in_clk : tx_multiframe_sync_out;
  etbts_top dut (.*);
  etbts_te_model te (.pclk(pclk), .rate(backplane_rate), .fsync_wire(tx_frame_sync_in),
    .ser_clk(ser_clk), .in_clk(in_clk), .dat(tx_serial_data));
  initial forever #20 pclk = ~pclk;
  // Bit period of 4 pclk; stops when run is low
  always @(posedge pclk)
  begin
    oscillator_clock <= ~oscillator_clock;
    ph <= ~ph;
    if (run && ph)
      recovered_clock <= ~recovered_clock;
  end
  // Edge and width counters
  always @(posedge tx_frame_sync_out) f++;
  always @(posedge tx_backplane_input_clock) n++;
  always @(posedge in_clk) m++;
  always @(negedge pclk)
  begin
    hi += tx_frame_sync_out;
    mh += tx_multiframe_sync_out;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic t_regs();
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'h1, 12'h000, 32'h10);
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h10);
    apb(1'h0, 12'h060, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'h1, 12'h000, 32'h0);
  endtask
  task automatic t_rates();
    for (int k = 0; k < 8; k++)
    begin
      apb(1'h1, 12'h020, k);
      apb(1'h0, 12'h020, 32'h0);
      chk(rd, k);
      chk({channel_muxed, backplane_rate}, {k[2], k[2:0]});
      chk(tx_multiframe_sync_oen_n, k inside {1, 2, 3});
      chk(tx_serial_clock_oen_n, k inside {1, 2, 3});
    end
  endtask
  task automatic t_mvip();
    for (int k = 1; k < 4; k++)
    begin
      apb(1'h1, 12'h020, k);
      // Let pin direction and rate settle before counting edges
      repeat (4) @(posedge pclk);
      n = 0;
      m = 0;
      repeat (120) @(posedge pclk);
      chk(n >= m - 1 && n <= m + 1, 1);
    end
  endtask
  task automatic t_sync();
    apb(1'h1, 12'h020, 32'h0);
    @(posedge tx_frame_sync_out);
    t = $time;
    @(posedge tx_frame_sync_out);
    chk($time - t, 32'hA000);
    @(posedge tx_multiframe_sync_out);
    #5 a = f;
    b = hi;
    c = mh;
    d = te.frames_seen;
    @(posedge tx_multiframe_sync_out);
    #5 chk(f - a, 16);
    chk(te.frames_seen - d, 16);
    chk(hi - b, 64);
    chk(mh - c, 4);
  endtask
  task automatic t_fallback();
    apb(1'h1, 12'h000, 32'h10);
    run <= 1'h0;
    repeat (40) @(posedge pclk);
    chk(fallback_active, 1'h0);
    repeat (20) @(posedge pclk);
    chk(fallback_active, 1'h1);
    chk(tx_timing_clock, !oscillator_clock);
    apb(1'h0, 12'h040, 32'h0);
    chk(rd, 32'h3);
    run <= 1'h1;
    repeat (8) @(posedge pclk);
    chk(fallback_active, 1'h0);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'h1, 12'h000, k == 0 ? 32'h0 : 32'h10 + k);
      run <= 1'h0;
      repeat (80) @(posedge pclk);
      chk(fallback_active, 1'h0);
      if (k == 2)
        chk(tx_timing_clock, !oscillator_clock);
      run <= 1'h1;
    end
    // Source code 11 is loop timing as well
    apb(1'h1, 12'h000, 32'h13);
    run <= 1'h0;
    repeat (60) @(posedge pclk);
    chk(fallback_active, 1'h1);
    run <= 1'h1;
    repeat (8) @(posedge pclk);
    chk(fallback_active, 1'h0);
  endtask
  task automatic finish_test();
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well past two multiframes
  initial
  begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_rates();
    t_mvip();
    t_sync();
    t_fallback();
    finish_test();
  end
endmodule
bind etbts_top etbts_checker u_chk (.*);
